// [shared/conv_result_params.svh]
// offsets, field positions, reset values and select codes of the result bank
// assumes byte addresses on an 8-bit register port
`ifndef CONV_RESULT_PARAMS_SVH
`define CONV_RESULT_PARAMS_SVH

`define CONV_ADDR_W 8
`define CONV_OFS_INT_SUPPLY_LOW 8'h03
`define CONV_OFS_EXT_INPUTS_LOW 8'h04
`define CONV_OFS_SUPPLY_HIGH 8'h06
`define CONV_OFS_INT_TEMP_HIGH 8'h07
`define CONV_OFS_EXT_INPUT1_HIGH 8'h08
`define CONV_OFS_INPUT2_HIGH 8'h09

// field positions inside the two shared low-bits registers
`define CONV_POS_INT_TEMP_LOW 0
`define CONV_POS_SUPPLY_LOW 2
`define CONV_POS_EXT_INPUT1_LOW 0
`define CONV_POS_INPUT2_LOW 2
`define CONV_POS_INPUT3_LOW 4
`define CONV_POS_INPUT4_LOW 6

`define CONV_RST_LOW 8'h00
`define CONV_RST_HIGH 8'h00
`define CONV_RD_IDLE 8'h00
`define CONV_UNUSED_BITS_MASK 8'hF0

// input_source_select code that routes the external temperature result
`define CONV_SEL_EXT_TEMP 2'h1
`define CONV_RESULT_W 10

`endif

// [shared/conv_result_pkg.sv]
// types shared by the conversion result bank and its bench
// assumes nothing of its surroundings
package conv_result_pkg;
    typedef logic [9:0] result_t;
    typedef logic [7:0] reg_byte_t;
    typedef logic [7:0] reg_addr_t;
    typedef logic [1:0] source_sel_t;
endpackage

// [core/conversion_result_registers.sv]
// read-only bank of 10-bit conversion results, split into high and low bytes
// assumes converter strobes and the source select come from i_core_clk logic
//
// Behaviour
// - internal temperature bits 1:0 go to bits 1:0 of register 0x03.
// - supply bits 1:0 go to bits 3:2 of 0x03; bits 7:4 unused.
// - bits 1:0 of 0x04 hold external temperature or input one, per select.
// - 0x04 bits 3:2, 5:4, 7:6 hold low bits of inputs two to four.
// - register 0x06 holds supply result bits 9 down to 2.
// - supply high register loads the measured supply at power-up, not zero.
// - register 0x07 holds internal temperature bits 9:2, two's complement.
// - register 0x08 holds bits 9:2 of the selected source.
// - external temperature kept two's complement across 0x08 and 0x04.
// - register 0x09 holds input two bits 9:2, joining 0x04 bits 3:2.
// - defined bits of 0x03, 0x04, 0x07, 0x08, 0x09 reset to zero.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "conv_result_params.svh"

module conversion_result_registers #(
    parameter int RESULT_W = `CONV_RESULT_W
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire conv_result_pkg::reg_addr_t i_addr,
    input wire conv_result_pkg::reg_byte_t i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output conv_result_pkg::reg_byte_t o_rd_data,
    output logic o_wr_ignored,
    input wire conv_result_pkg::source_sel_t i_input_source_select,
    input wire logic i_int_temp_valid,
    input wire conv_result_pkg::result_t i_int_temp_data,
    input wire logic i_supply_valid,
    input wire conv_result_pkg::result_t i_supply_data,
    input wire logic i_ext_temp_valid,
    input wire conv_result_pkg::result_t i_ext_temp_data,
    input wire logic i_analog_input_one_valid,
    input wire conv_result_pkg::result_t i_analog_input_one_data,
    input wire logic i_analog_input_two_valid,
    input wire conv_result_pkg::result_t i_analog_input_two_data,
    input wire logic i_analog_input_three_valid,
    input wire conv_result_pkg::result_t i_analog_input_three_data,
    input wire logic i_analog_input_four_valid,
    input wire conv_result_pkg::result_t i_analog_input_four_data
);
    import conv_result_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // elaboration check

    // byte split below is fixed at ten bits
    if (RESULT_W != 10) begin : g_bad_width
        $error("result width must be ten bits");
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic reg_byte_t high_bits(input result_t r);
        high_bits = r[9:2];
    endfunction

    function automatic logic [1:0] low_bits(input result_t r);
        low_bits = r[1:0];
    endfunction

    function automatic logic is_mapped(input reg_addr_t a);
        is_mapped = (a == `CONV_OFS_INT_SUPPLY_LOW) ||
                    (a == `CONV_OFS_EXT_INPUTS_LOW) ||
                    (a == `CONV_OFS_SUPPLY_HIGH) ||
                    (a == `CONV_OFS_INT_TEMP_HIGH) ||
                    (a == `CONV_OFS_EXT_INPUT1_HIGH) ||
                    (a == `CONV_OFS_INPUT2_HIGH);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // storage

    reg_byte_t int_supply_low_ff;
    reg_byte_t ext_inputs_low_ff;
    reg_byte_t supply_high_ff;
    reg_byte_t int_temp_high_ff;
    reg_byte_t ext_input1_high_ff;
    reg_byte_t input2_high_ff;
    reg_byte_t rd_data_ff;
    logic wr_ignored_ff;

    logic ext_selected;
    logic shared_valid;
    result_t shared_data;

    assign ext_selected = (i_input_source_select == `CONV_SEL_EXT_TEMP);

    // external temperature passes through unaltered, so sign is kept
    always_comb begin
        if (ext_selected) begin
            shared_valid = i_ext_temp_valid;
            shared_data = i_ext_temp_data;
        end else begin
            shared_valid = i_analog_input_one_valid;
            shared_data = i_analog_input_one_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register 0x03

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            int_supply_low_ff <= `CONV_RST_LOW;
        end else begin
            if (i_int_temp_valid) begin
                int_supply_low_ff[`CONV_POS_INT_TEMP_LOW +: 2] <= low_bits(i_int_temp_data);
            end
            if (i_supply_valid) begin
                int_supply_low_ff[`CONV_POS_SUPPLY_LOW +: 2] <= low_bits(i_supply_data);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register 0x04

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ext_inputs_low_ff <= `CONV_RST_LOW;
        end else begin
            if (shared_valid) begin
                ext_inputs_low_ff[`CONV_POS_EXT_INPUT1_LOW +: 2] <= low_bits(shared_data);
            end
            // inputs two to four, lower bit first
            if (i_analog_input_two_valid) begin
                ext_inputs_low_ff[`CONV_POS_INPUT2_LOW +: 2] <= low_bits(i_analog_input_two_data);
            end
            if (i_analog_input_three_valid) begin
                ext_inputs_low_ff[`CONV_POS_INPUT3_LOW +: 2] <= low_bits(i_analog_input_three_data);
            end
            if (i_analog_input_four_valid) begin
                ext_inputs_low_ff[`CONV_POS_INPUT4_LOW +: 2] <= low_bits(i_analog_input_four_data);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register 0x06

    // reset samples the live supply measurement instead of zero
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            supply_high_ff <= high_bits(i_supply_data);
        end else if (i_supply_valid) begin
            supply_high_ff <= high_bits(i_supply_data);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers 0x07, 0x08, 0x09

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            int_temp_high_ff <= `CONV_RST_HIGH;
        end else if (i_int_temp_valid) begin
            // sign bit lands in bit 7
            int_temp_high_ff <= high_bits(i_int_temp_data);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ext_input1_high_ff <= `CONV_RST_HIGH;
        end else if (shared_valid) begin
            ext_input1_high_ff <= high_bits(shared_data);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            input2_high_ff <= `CONV_RST_HIGH;
        end else if (i_analog_input_two_valid) begin
            input2_high_ff <= high_bits(i_analog_input_two_data);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port

    // read data stands one cycle only, idle value otherwise
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rd_data_ff <= `CONV_RD_IDLE;
        end else if (i_rd_en) begin
            unique case (i_addr)
                // unused upper bits forced to zero
                `CONV_OFS_INT_SUPPLY_LOW: rd_data_ff <= int_supply_low_ff & ~`CONV_UNUSED_BITS_MASK;
                `CONV_OFS_EXT_INPUTS_LOW: rd_data_ff <= ext_inputs_low_ff;
                `CONV_OFS_SUPPLY_HIGH: rd_data_ff <= supply_high_ff;
                `CONV_OFS_INT_TEMP_HIGH: rd_data_ff <= int_temp_high_ff;
                `CONV_OFS_EXT_INPUT1_HIGH: rd_data_ff <= ext_input1_high_ff;
                `CONV_OFS_INPUT2_HIGH: rd_data_ff <= input2_high_ff;
                default: rd_data_ff <= `CONV_RD_IDLE;
            endcase
        end else begin
            rd_data_ff <= `CONV_RD_IDLE;
        end
    end

    // writes never reach storage; flag those to mapped offsets for software debug
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wr_ignored_ff <= 1'b0;
        end else begin
            wr_ignored_ff <= i_wr_en && is_mapped(i_addr);
        end
    end

    assign o_rd_data = rd_data_ff;
    assign o_wr_ignored = wr_ignored_ff;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    logic any_result_valid;
    assign any_result_valid = i_int_temp_valid | i_supply_valid | i_ext_temp_valid |
        i_analog_input_one_valid | i_analog_input_two_valid |
        i_analog_input_three_valid | i_analog_input_four_valid;

    sequence s_read_req(reg_addr_t a);
        i_rd_en && (i_addr == a);
    endsequence

    sequence s_ext_store;
        ext_selected && i_ext_temp_valid;
    endsequence

    a_int_temp_low: assert property (
        i_int_temp_valid |=> int_supply_low_ff[1:0] == $past(i_int_temp_data[1:0]))
        else $error("internal temperature low bits not stored");

    a_supply_low_read: assert property (
        i_supply_valid ##1 s_read_req(`CONV_OFS_INT_SUPPLY_LOW)
        |=> o_rd_data == {4'h0, $past(i_supply_data[1:0], 2), $past(int_supply_low_ff[1:0])})
        else $error("supply low bits or unused bits wrong on read");

    a_shared_low_sel: assert property (
        (!ext_selected && i_analog_input_one_valid)
        |=> ext_inputs_low_ff[1:0] == $past(i_analog_input_one_data[1:0]))
        else $error("input one low bits not stored when selected");

    a_input3_low: assert property (
        i_analog_input_three_valid |=> ext_inputs_low_ff[5:4] == $past(i_analog_input_three_data[1:0]))
        else $error("input three low bits misplaced");

    a_supply_high: assert property (
        i_supply_valid ##1 s_read_req(`CONV_OFS_SUPPLY_HIGH)
        |=> o_rd_data == $past(i_supply_data[9:2], 2))
        else $error("supply high bits read wrong");

    // reset-time checks must not be switched off by the reset they watch
    a_supply_powerup: assert property (@(posedge i_core_clk) disable iff (1'b0)
        i_rst |=> supply_high_ff == $past(i_supply_data[9:2]))
        else $error("supply high bits not loaded at reset");

    a_int_temp_high: assert property (
        i_int_temp_valid |=> int_temp_high_ff[7] == $past(i_int_temp_data[9]))
        else $error("internal temperature sign bit misplaced");

    a_ext_full_word: assert property (
        s_ext_store |=> {ext_input1_high_ff, ext_inputs_low_ff[1:0]} == $past(i_ext_temp_data))
        else $error("external temperature word split wrong");

    a_ext_ignored: assert property (
        (!ext_selected && !i_analog_input_one_valid) |=> $stable(ext_input1_high_ff))
        else $error("unselected source reached register 0x08");

    a_input2_word: assert property (
        i_analog_input_two_valid
        |=> {input2_high_ff, ext_inputs_low_ff[3:2]} == $past(i_analog_input_two_data))
        else $error("input two word split wrong");

    a_reset_zero: assert property (@(posedge i_core_clk) disable iff (1'b0)
        i_rst |=> int_supply_low_ff == 8'h00 && ext_inputs_low_ff == 8'h00 &&
            int_temp_high_ff == 8'h00 && ext_input1_high_ff == 8'h00 && input2_high_ff == 8'h00)
        else $error("result registers not zero after reset");

    a_write_ignored: assert property (
        (i_wr_en && !any_result_valid)
        |=> $stable(int_supply_low_ff) && $stable(ext_inputs_low_ff) && $stable(supply_high_ff) &&
            $stable(int_temp_high_ff) && $stable(ext_input1_high_ff) && $stable(input2_high_ff))
        else $error("host write changed a result register");

    a_unmapped_zero: assert property (
        (i_rd_en && !is_mapped(i_addr)) |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");

    a_read_one_cycle: assert property (
        !i_rd_en |=> o_rd_data == 8'h00)
        else $error("read data held past its cycle");

    a_ext_dropped: assert property (
        (!ext_selected && i_ext_temp_valid && !i_analog_input_one_valid)
        |=> $stable(ext_input1_high_ff) && $stable(ext_inputs_low_ff[1:0]))
        else $error("unselected external result reached the shared slot");

    a_input1_dropped: assert property (
        (ext_selected && i_analog_input_one_valid && !i_ext_temp_valid)
        |=> $stable(ext_input1_high_ff) && $stable(ext_inputs_low_ff[1:0]))
        else $error("unselected input one result reached the shared slot");

    a_input4_low: assert property (
        i_analog_input_four_valid |=> ext_inputs_low_ff[7:6] == $past(i_analog_input_four_data[1:0]))
        else $error("input four low bits misplaced");

    a_int_temp_word: assert property (
        i_int_temp_valid |=> {int_temp_high_ff, int_supply_low_ff[1:0]} == $past(i_int_temp_data))
        else $error("internal temperature word split wrong");

    a_unused_bits_zero: assert property (
        s_read_req(`CONV_OFS_INT_SUPPLY_LOW) |=> o_rd_data[7:4] == 4'h0)
        else $error("unused bits of register 0x03 not zero");

    a_wr_flag_pulse: assert property (
        (i_wr_en && is_mapped(i_addr)) |=> o_wr_ignored)
        else $error("write to a result register not flagged");

    a_wr_flag_idle: assert property (
        !i_wr_en |=> !o_wr_ignored)
        else $error("write flag held past its cycle");

    a_reset_outputs: assert property (@(posedge i_core_clk) disable iff (1'b0)
        i_rst |=> o_rd_data == 8'h00 && !o_wr_ignored)
        else $error("port outputs not idle after reset");

endmodule

// [bench/tb_conversion_result_registers.sv]
// self-checking bench for the read-only conversion result bank
// assumes the params header is on the include path; drives every port itself
`timescale 1ns/10ps
`include "conv_result_params.svh"

module tb_conversion_result_registers;
    import conv_result_pkg::*;

    logic i_core_clk = 1'b0;
    logic i_rst;
    reg_addr_t i_addr;
    reg_byte_t i_wr_data;
    logic i_wr_en;
    logic i_rd_en;
    reg_byte_t o_rd_data;
    logic o_wr_ignored;
    source_sel_t i_input_source_select;
    // source order: int temp, supply, ext temp, input one..four
    logic [6:0] vld;
    result_t dat [7];
    result_t lat [7];
    result_t shared_val;
    int err_total = 0;
    int check_count = 0;

    always #5 i_core_clk = ~i_core_clk;

    conversion_result_registers u_conversion_result_registers (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_addr(i_addr),
        .i_wr_data(i_wr_data),
        .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en),
        .o_rd_data(o_rd_data),
        .o_wr_ignored(o_wr_ignored),
        .i_input_source_select(i_input_source_select),
        .i_int_temp_valid(vld[0]),
        .i_int_temp_data(dat[0]),
        .i_supply_valid(vld[1]),
        .i_supply_data(dat[1]),
        .i_ext_temp_valid(vld[2]),
        .i_ext_temp_data(dat[2]),
        .i_analog_input_one_valid(vld[3]),
        .i_analog_input_one_data(dat[3]),
        .i_analog_input_two_valid(vld[4]),
        .i_analog_input_two_data(dat[4]),
        .i_analog_input_three_valid(vld[5]),
        .i_analog_input_three_data(dat[5]),
        .i_analog_input_four_valid(vld[6]),
        .i_analog_input_four_data(dat[6])
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input reg_byte_t exp, input reg_byte_t got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input reg_addr_t a, input reg_byte_t exp);
        @(posedge i_core_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd_en <= 1'b0;
        #1;
        chk($sformatf("read %h", a), exp, o_rd_data);
    endtask

    task automatic wr_chk(input reg_addr_t a, input logic exp_ign);
        @(posedge i_core_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= 8'hFF;
        @(posedge i_core_clk);
        i_wr_en <= 1'b0;
        #1;
        chk($sformatf("write flag %h", a), {7'h00, exp_ign}, {7'h00, o_wr_ignored});
        // flag stands one cycle only
        @(posedge i_core_clk);
        #1;
        chk("write flag end", 8'h00, {7'h00, o_wr_ignored});
    endtask

    // bench copy of what each register should hold after the pulse
    task automatic post(input logic [6:0] m, input result_t v [7]);
        @(posedge i_core_clk);
        vld <= m;
        for (int k = 0; k < 7; k++) begin
            dat[k] <= v[k];
            if (m[k]) begin
                lat[k] = v[k];
            end
        end
        if (m[2] && i_input_source_select === `CONV_SEL_EXT_TEMP) begin
            shared_val = v[2];
        end
        if (m[3] && i_input_source_select !== `CONV_SEL_EXT_TEMP) begin
            shared_val = v[3];
        end
        @(posedge i_core_clk);
        vld <= 7'h00;
    endtask

    task automatic check_all;
        rd_chk(`CONV_OFS_INT_SUPPLY_LOW, {4'h0, lat[1][1:0], lat[0][1:0]});
        rd_chk(`CONV_OFS_EXT_INPUTS_LOW, {lat[6][1:0], lat[5][1:0], lat[4][1:0], shared_val[1:0]});
        rd_chk(`CONV_OFS_SUPPLY_HIGH, lat[1][9:2]);
        rd_chk(`CONV_OFS_INT_TEMP_HIGH, lat[0][9:2]);
        rd_chk(`CONV_OFS_EXT_INPUT1_HIGH, shared_val[9:2]);
        rd_chk(`CONV_OFS_INPUT2_HIGH, lat[4][9:2]);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset(input result_t sup);
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        dat[1] <= sup;
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        #1;
        chk("reset read data", 8'h00, o_rd_data);
        chk("reset write flag", 8'h00, {7'h00, o_wr_ignored});
        for (int k = 0; k < 7; k++) begin
            lat[k] = '0;
        end
        // supply high byte keeps the measured value, low pair clears
        lat[1] = {sup[9:2], 2'b00};
        shared_val = '0;
        check_all();
        rd_chk(8'h05, 8'h00);
        rd_chk(8'h0A, 8'h00);
        @(posedge i_core_clk);
        #1;
        chk("read idle", `CONV_RD_IDLE, o_rd_data);
        $display("test reset %h done", sup);
    endtask

    task automatic test_ext_selected;
        result_t v [7] = '{10'h3FD, 10'h2B6, 10'h3F2, 10'h155, 10'h0CB, 10'h1E6, 10'h27D};
        @(posedge i_core_clk);
        i_input_source_select <= `CONV_SEL_EXT_TEMP;
        post(7'h7F, v);
        check_all();
        $display("test ext selected done");
    endtask

    task automatic test_input_one_selected;
        result_t v [7] = '{10'h200, 10'h001, 10'h1FF, 10'h000, 10'h3FF, 10'h000, 10'h3FF};
        for (int c = 0; c < 4; c++) begin
            if (c != 1) begin
                @(posedge i_core_clk);
                i_input_source_select <= source_sel_t'(c);
                v[3] = 10'h2A6 + result_t'(c);
                post(7'h0C, v);
                check_all();
            end
        end
        post(7'h7F, v);
        check_all();
        $display("test input one selected done");
    endtask

    // a lone result from the source that is not selected must leave the shared slot alone
    task automatic test_dropped;
        result_t v [7] = '{10'h0F0, 10'h0F0, 10'h0A9, 10'h356, 10'h0F0, 10'h0F0, 10'h0F0};
        @(posedge i_core_clk);
        i_input_source_select <= `CONV_SEL_EXT_TEMP;
        post(7'h08, v);
        check_all();
        @(posedge i_core_clk);
        i_input_source_select <= 2'h2;
        post(7'h04, v);
        check_all();
        $display("test dropped sources done");
    endtask

    task automatic test_writes;
        reg_addr_t ofs [6] = '{`CONV_OFS_INT_SUPPLY_LOW, `CONV_OFS_EXT_INPUTS_LOW, `CONV_OFS_SUPPLY_HIGH,
            `CONV_OFS_INT_TEMP_HIGH, `CONV_OFS_EXT_INPUT1_HIGH, `CONV_OFS_INPUT2_HIGH};
        foreach (ofs[k]) begin
            wr_chk(ofs[k], 1'b1);
        end
        wr_chk(8'h05, 1'b0);
        check_all();
        $display("test writes done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'b1;
        i_addr = 8'h00;
        i_wr_data = 8'h00;
        i_wr_en = 1'b0;
        i_rd_en = 1'b0;
        i_input_source_select = 2'h0;
        vld = 7'h00;
        for (int k = 0; k < 7; k++) begin
            dat[k] = '0;
        end
        test_reset(10'h2B6);
        test_ext_selected();
        test_input_one_selected();
        test_dropped();
        test_writes();
        // second reset in mid-run must clear all results again but the supply high byte
        test_reset(10'h35D);
        end_of_test();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge i_core_clk);
        err_total++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        end_of_test();
    end
endmodule
